// ### rtl/embp_pkg.sv
// package for the external memory bus pin block
package embp_pkg;
    localparam int ADDR_W = 26;
    localparam int PIN_A_W = 13;
    localparam int DATA_W = 32;
    localparam int UPPER_LSB = 13;
    localparam int ALE_CYCLES = 2;
    localparam int STROBE_CYCLES = 4;
    localparam int TURN_CYCLES = 1;

    typedef enum logic [2:0] {
        EMBP_TGT_CS,
        EMBP_TGT_MCS,
        EMBP_TGT_CARD1,
        EMBP_TGT_CARD2,
        EMBP_TGT_DRAM,
        EMBP_TGT_SDRAM8,
        EMBP_TGT_SDRAM16,
        EMBP_TGT_SHOW
    } embp_tgt_e;

    typedef struct packed {
        logic valid;
        logic write;
        embp_tgt_e tgt;
        logic [1:0] sel;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [3:0] be;
    } embp_req_s;

    typedef struct packed {
        logic [PIN_A_W-1:0] addr;
        logic ale;
        logic rd_n;
        logic we_n;
        logic [3:0] byte_lane_strobe_n;
        logic [3:0] general_chip_selects_n;
        logic [3:0] card_slot_chip_selects_n;
        logic first_pc_card_select_n;
        logic second_pc_card_select_n;
        logic [DATA_W-1:0] dout;
        logic d_oe_n;
    } embp_pins_s;
endpackage

// ### rtl/embp_lane.sv
`timescale 1ns/1ps
// byte lane placement for each port type
module embp_lane (
    input wire embp_pkg::embp_tgt_e tgt,
    input wire logic wide32,
    input wire logic [3:0] be,
    input wire logic [31:0] wdata,
    output logic [3:0] lane_be,
    output logic [31:0] lane_data
);
    always_comb begin
        lane_be = be;
        lane_data = wdata;
        case (tgt)
            embp_pkg::EMBP_TGT_SDRAM8: begin
                lane_be = {3'h0, be[0]};
                lane_data = {24'h0, wdata[7:0]};
            end
            embp_pkg::EMBP_TGT_SDRAM16, embp_pkg::EMBP_TGT_DRAM: begin
                lane_be = {2'h0, be[1:0]};
                lane_data = {16'h0, wdata[15:0]};
            end
            embp_pkg::EMBP_TGT_MCS, embp_pkg::EMBP_TGT_CARD1, embp_pkg::EMBP_TGT_CARD2: begin
                lane_be = {be[1:0], 2'h0};
                lane_data = {wdata[15:0], 16'h0};
            end
            embp_pkg::EMBP_TGT_CS: begin
                if (!wide32) begin
                    lane_be = {be[1:0], 2'h0};
                    lane_data = {wdata[15:0], 16'h0};
                end
            end
            default: begin
                lane_be = be;
                lane_data = wdata;
            end
        endcase
    end
endmodule

// ### rtl/embp_bus.sv
`timescale 1ns/1ps
// external memory bus pin sequencer
module embp_bus (
    input wire logic ref_clk,
    input wire logic rst,
    input wire embp_pkg::embp_req_s req,
    output logic req_ready,
    input wire logic [3:0] cs_wide32,
    input wire logic internal_access_show_mode,
    input wire logic [31:0] d_in,
    output logic [31:0] rdata,
    output logic rdata_valid,
    output embp_pkg::embp_pins_s pins
);
    typedef enum logic [2:0] {ST_IDLE, ST_ALE, ST_SETUP, ST_STROBE, ST_TURN} embp_st_e;

    typedef struct packed {
        embp_st_e st;
        logic [3:0] cnt;
        embp_pkg::embp_req_s cur;
        embp_pkg::embp_pins_s pins;
        logic [31:0] rdata;
        logic rvalid;
        logic [31:0] din1;
        logic [31:0] din2;
    } embp_state_s;

    embp_state_s s_r;
    embp_state_s s_nxt;
    logic [3:0] lane_be;
    logic [31:0] lane_data;
    logic wide32;

    // dynamic parts take row and column on the same pins and need no latch
    function automatic logic is_dynamic(input embp_pkg::embp_tgt_e t);
        logic dyn;
        dyn = 1'b0;
        case (t)
            embp_pkg::EMBP_TGT_DRAM: dyn = 1'b1;
            embp_pkg::EMBP_TGT_SDRAM8: dyn = 1'b1;
            embp_pkg::EMBP_TGT_SDRAM16: dyn = 1'b1;
            default: dyn = 1'b0;
        endcase
        return dyn;
    endfunction

    function automatic logic needs_latch(input embp_pkg::embp_tgt_e t);
        return !is_dynamic(t);
    endfunction

    // show cycles only reach the pins while the debug mode is on
    function automatic logic is_dropped(input embp_pkg::embp_tgt_e t, input logic show_on);
        return (t == embp_pkg::EMBP_TGT_SHOW) && !show_on;
    endfunction

    // counters start at zero, so a phase of n counts ends when the count reads n - 1
    function automatic logic last_count(input logic [3:0] cnt, input int n);
        return cnt == 4'(n - 1);
    endfunction

    function automatic embp_pkg::embp_pins_s idle_pins(input embp_pkg::embp_pins_s p);
        embp_pkg::embp_pins_s q;
        q = p;
        q.ale = 1'b0;
        q.rd_n = 1'b1;
        q.we_n = 1'b1;
        q.byte_lane_strobe_n = 4'hf;
        q.general_chip_selects_n = 4'hf;
        q.card_slot_chip_selects_n = 4'hf;
        q.first_pc_card_select_n = 1'b1;
        q.second_pc_card_select_n = 1'b1;
        q.d_oe_n = 1'b0;
        return q;
    endfunction

    // one select low for the addressed port, every other select left high
    function automatic embp_pkg::embp_pins_s select_pins(input embp_pkg::embp_pins_s p,
        input embp_pkg::embp_tgt_e t, input logic [1:0] sel);
        embp_pkg::embp_pins_s q;
        q = p;
        case (t)
            embp_pkg::EMBP_TGT_CS: begin
                q.general_chip_selects_n[sel] = 1'b0;
            end
            embp_pkg::EMBP_TGT_MCS: begin
                q.card_slot_chip_selects_n[sel] = 1'b0;
            end
            embp_pkg::EMBP_TGT_CARD1: begin
                q.first_pc_card_select_n = 1'b0;
            end
            embp_pkg::EMBP_TGT_CARD2: begin
                q.second_pc_card_select_n = 1'b0;
            end
            default: begin
                // dynamic and show cycles use no static select
                q.first_pc_card_select_n = 1'b1;
            end
        endcase
        return q;
    endfunction

    // strobe levels for one count of the strobe phase
    function automatic embp_pkg::embp_pins_s strobe_pins(input embp_pkg::embp_pins_s p,
        input embp_pkg::embp_req_s r, input logic [3:0] be);
        embp_pkg::embp_pins_s q;
        q = p;
        if (r.write) begin
            q.we_n = 1'b0;
            q.byte_lane_strobe_n = ~be;
        end else if (!is_dynamic(r.tgt)) begin
            q.rd_n = 1'b0;
        end else begin
            // dynamic reads use the column strobes and leave the read pin alone
            q.byte_lane_strobe_n = ~be;
        end
        return q;
    endfunction

    // strobes and selects drop together; a read keeps the data pins floating
    function automatic embp_pkg::embp_pins_s end_pins(input embp_pkg::embp_pins_s p,
        input logic write);
        embp_pkg::embp_pins_s q;
        q = idle_pins(p);
        q.d_oe_n = ~write;
        return q;
    endfunction

    assign wide32 = cs_wide32[s_r.cur.sel];

    embp_lane u_lane (
        .tgt(s_r.cur.tgt),
        .wide32(wide32),
        .be(s_r.cur.be),
        .wdata(s_r.cur.wdata),
        .lane_be(lane_be),
        .lane_data(lane_data)
    );

    assign req_ready = (s_r.st == ST_IDLE);
    assign pins = s_r.pins;
    assign rdata = s_r.rdata;
    assign rdata_valid = s_r.rvalid;

    always_comb begin
        s_nxt = s_r;
        s_nxt.din1 = d_in;
        s_nxt.din2 = s_r.din1;
        s_nxt.rvalid = 1'b0;
        case (s_r.st)
            ST_IDLE: begin
                if (req.valid && !is_dropped(req.tgt, internal_access_show_mode)) begin
                    s_nxt.cur = req;
                    s_nxt.cnt = 4'h0;
                    if (needs_latch(req.tgt)) begin
                        // upper bits ride the pins while the latch strobe is high
                        s_nxt.pins.addr = req.addr[embp_pkg::ADDR_W-1:embp_pkg::UPPER_LSB];
                        s_nxt.pins.ale = 1'b1;
                        s_nxt.st = ST_ALE;
                    end else begin
                        // dynamic parts take row then column on the same pins
                        s_nxt.pins.addr = req.addr[embp_pkg::ADDR_W-1:embp_pkg::UPPER_LSB];
                        s_nxt.st = ST_SETUP;
                    end
                end
            end
            ST_ALE: begin
                s_nxt.cnt = s_r.cnt + 4'h1;
                if (last_count(s_r.cnt, embp_pkg::ALE_CYCLES)) begin
                    s_nxt.pins.ale = 1'b0;
                    s_nxt.st = ST_SETUP;
                end
            end
            ST_SETUP: begin
                s_nxt.cnt = 4'h0;
                s_nxt.pins.addr = s_r.cur.addr[embp_pkg::PIN_A_W-1:0];
                s_nxt.pins = select_pins(s_nxt.pins, s_r.cur.tgt, s_r.cur.sel);
                if (s_r.cur.write) begin
                    // write data settles a cycle ahead of the write strobe
                    s_nxt.pins.dout = lane_data;
                    s_nxt.pins.d_oe_n = 1'b0;
                end else begin
                    s_nxt.pins.d_oe_n = 1'b1;
                end
                s_nxt.st = ST_STROBE;
            end
            ST_STROBE: begin
                // strobes only after the latch pulse has fully ended
                s_nxt.pins = strobe_pins(s_r.pins, s_r.cur, lane_be);
                s_nxt.cnt = s_r.cnt + 4'h1;
                // the first count only raises the strobes, so the phase is one count longer
                if (last_count(s_r.cnt, embp_pkg::STROBE_CYCLES + 1)) begin
                    if (!s_r.cur.write) begin
                        // two-flop sampled bus, so data seen is from two edges back
                        s_nxt.rdata = s_r.din2;
                        s_nxt.rvalid = 1'b1;
                    end
                    s_nxt.pins = end_pins(s_r.pins, s_r.cur.write);
                    s_nxt.cnt = 4'h0;
                    s_nxt.st = ST_TURN;
                end
            end
            ST_TURN: begin
                // a read leaves the bus floating one turnaround cycle
                s_nxt.cnt = s_r.cnt + 4'h1;
                if (last_count(s_r.cnt, embp_pkg::TURN_CYCLES)) begin
                    s_nxt.pins.d_oe_n = 1'b0;
                    s_nxt.st = ST_IDLE;
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.pins <= idle_pins('0);
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// ### bench/embp_bus_chk.sv
// assertions on the external memory bus pins
`timescale 1ns/1ps
module embp_bus_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic internal_access_show_mode,
    input wire logic rdata_valid,
    input wire embp_pkg::embp_pins_s pins
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic any_sel;
    assign any_sel = ~&{pins.general_chip_selects_n, pins.card_slot_chip_selects_n,
        pins.first_pc_card_select_n, pins.second_pc_card_select_n};
    sequence s_ale_pulse;
        pins.ale [*2] ##1 !pins.ale;
    endsequence
    sequence s_rd_strobe;
        !pins.rd_n [*4] ##1 pins.rd_n;
    endsequence
    AST_ALE_WIDTH: assert property ($rose(pins.ale) |-> s_ale_pulse)
        else $error("latch strobe width wrong");
    // reads are left out here while the show mode is on; show cycles take the latch phase as well
    AST_ALE_FIRST: assert property ($fell(pins.rd_n) && !internal_access_show_mode
        |-> $past(pins.ale, 3) && !$past(pins.ale, 2) && !$past(pins.ale))
        else $error("read strobe before latch");
    AST_RD_LEN: assert property ($fell(pins.rd_n) |-> s_rd_strobe)
        else $error("read strobe length wrong");
    AST_ADDR_HOLD: assert property ($fell(pins.rd_n) || ($fell(pins.we_n)
        && $past(pins.ale, 3)) |-> $stable(pins.addr) [*4]) else $error("address moved");
    AST_FLOAT_RD: assert property (!pins.rd_n |-> pins.d_oe_n)
        else $error("data driven in read");
    AST_DRIVE_WR: assert property (!pins.we_n |-> !pins.d_oe_n)
        else $error("data floated in write");
    AST_SEL_RD: assert property (!pins.rd_n && !internal_access_show_mode |-> any_sel)
        else $error("read without select");
    AST_RDATA: assert property ($rose(pins.rd_n) |-> rdata_valid)
        else $error("read data not returned");
    AST_WE_LANE: assert property ($fell(pins.we_n) |-> pins.byte_lane_strobe_n != 4'hf)
        else $error("write without lane strobe");
endmodule
bind embp_bus embp_bus_chk u_chk (.ref_clk(ref_clk), .rst(rst), .rdata_valid(rdata_valid),
    .internal_access_show_mode(internal_access_show_mode), .pins(pins));

// ### bench/embp_mem_model.sv
// behavioural memory on the far side of the pin block
`timescale 1ns/1ps
module embp_mem_model (
    input wire logic ref_clk,
    input wire embp_pkg::embp_pins_s pins,
    output logic [31:0] d_in
);
    logic [12:0] upper_r = 13'h0000;
    logic [31:0] mem [0:255];
    logic [7:0] idx;
    assign idx = {upper_r[3:0], pins.addr[3:0]};
    initial begin
        d_in = 32'h0000_0000;
        foreach (mem[i]) mem[i] = 32'h0000_0000;
    end
    always @(posedge ref_clk) begin
        if (pins.ale) upper_r <= pins.addr;
        for (int i = 0; i < 4; i++) begin
            if (!pins.we_n && !pins.byte_lane_strobe_n[i]) mem[idx][8*i+:8] <= pins.dout[8*i+:8];
        end
        // released bus toggles, so a stale value never reads as good
        d_in <= (!pins.rd_n && pins.d_oe_n) ? mem[idx] : ~d_in;
    end
endmodule

// ### bench/embp_bus_tb.sv
// self-checking bench for the external memory bus pin block
`timescale 1ns/1ps
module embp_bus_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    embp_pkg::embp_req_s req = '0;
    logic show = 1'b0;
    logic [31:0] d_in, rdata;
    logic rdata_valid, req_ready;
    embp_pkg::embp_pins_s pins;
    int err_total = 0;
    int total_checks = 0;
    always #2.5 ref_clk = ~ref_clk;
    embp_bus DUT (.ref_clk(ref_clk), .rst(rst), .req(req), .req_ready(req_ready),
        .cs_wide32(4'h1), .internal_access_show_mode(show), .d_in(d_in), .rdata(rdata),
        .rdata_valid(rdata_valid), .pins(pins));
    embp_mem_model mem (.ref_clk(ref_clk), .pins(pins), .d_in(d_in));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic send(input logic w, input embp_pkg::embp_tgt_e t, input logic [1:0] s,
        input logic [25:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge ref_clk);
        req <= '{1'b1, w, t, s, a, d, be};
        @(negedge ref_clk);
        while (!req_ready) @(negedge ref_clk);
        @(posedge ref_clk);
        req.valid <= 1'b0;
    endtask
    task automatic await(input logic wr, output logic seen);
        seen = 1'b0;
        for (int n = 0; n < 16 && !seen; n++) begin
            @(negedge ref_clk);
            seen = ((wr ? pins.we_n : pins.rd_n) === 1'b0);
        end
    endtask
    task automatic wr(input embp_pkg::embp_tgt_e t, input logic [1:0] s, input logic [25:0] a,
        input logic [31:0] d, input logic [3:0] be, input logic [3:0] n, input logic [31:0] e);
        logic seen;
        logic [31:0] m;
        logic [9:0] sx;
        logic [9:0] sg;
        for (int i = 0; i < 4; i++) m[8*i+:8] = {8{~n[i]}};
        // selects in pin order: general 3..0, card slot 3..0, first card, second card
        sx = 10'h3ff;
        if (t == embp_pkg::EMBP_TGT_CS) sx[6 + s] = 1'b0;
        if (t == embp_pkg::EMBP_TGT_MCS) sx[2 + s] = 1'b0;
        send(1'b1, t, s, a, d, be);
        await(1'b1, seen);
        sg = {pins.general_chip_selects_n, pins.card_slot_chip_selects_n,
            pins.first_pc_card_select_n, pins.second_pc_card_select_n};
        chk("write strobe", 32'h1, {31'h0, seen});
        chk("lane strobes", {28'h0, n}, {28'h0, pins.byte_lane_strobe_n});
        chk("data lanes", e, pins.dout & m);
        chk("selects", {22'h0, sx}, {22'h0, sg});
    endtask
    task automatic rd(input embp_pkg::embp_tgt_e t, input logic [25:0] a, input logic x,
        input logic cd, input logic [31:0] e);
        logic seen;
        send(1'b0, t, 2'h0, a, 32'h0, 4'hf);
        await(1'b0, seen);
        chk("read strobe", {31'h0, x}, {31'h0, seen});
        if (x) begin
            repeat (4) @(negedge ref_clk);
            chk("read done", 32'h1, {31'h0, rdata_valid});
            if (cd) chk("read data", e, rdata);
        end
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk("idle pins", 32'hc, {28'h0, pins.rd_n, pins.we_n, pins.ale, pins.d_oe_n});
        wr(embp_pkg::EMBP_TGT_CS, 0, 26'h3ffe005, 32'h8421c3a5, 4'hf, 4'h0, 32'h8421c3a5);
        rd(embp_pkg::EMBP_TGT_CS, 26'h3ffe005, 1, 1, 32'h8421c3a5);
        wr(embp_pkg::EMBP_TGT_CS, 1, 26'h6, 32'h5a3c, 4'h3, 4'h3, 32'h5a3c0000);
        wr(embp_pkg::EMBP_TGT_MCS, 2, 26'h7, 32'h5a3c, 4'h3, 4'h3, 32'h5a3c0000);
        wr(embp_pkg::EMBP_TGT_SDRAM16, 0, 26'ha, 32'h96e1, 4'h3, 4'hc, 32'h96e1);
        wr(embp_pkg::EMBP_TGT_SDRAM8, 0, 26'hb, 32'h77, 4'h1, 4'he, 32'h77);
        wr(embp_pkg::EMBP_TGT_DRAM, 0, 26'hc, 32'h1e2d, 4'h3, 4'hc, 32'h1e2d);
        rd(embp_pkg::EMBP_TGT_CARD1, 26'h6, 1, 1, 32'h5a3c0000);
        rd(embp_pkg::EMBP_TGT_CARD2, 26'h9, 1, 0, 32'h0);
        rd(embp_pkg::EMBP_TGT_DRAM, 26'hd, 0, 0, 32'h0);
        rd(embp_pkg::EMBP_TGT_SHOW, 26'h9, 0, 0, 32'h0);
        @(posedge ref_clk);
        show <= 1'b1;
        rd(embp_pkg::EMBP_TGT_SHOW, 26'h9, 1, 0, 32'h0);
        summarize();
    end
    initial begin
        repeat (2000) @(posedge ref_clk);
        err_total++;
        summarize();
    end
endmodule
